// File: drc_base.sv
// Purpose: Shared constants and the pin input synchroniser of the data recorder.
// Assumes: One system clock; pins change asynchronously to it.
// Notes: Memory addresses are byte addresses of the recorder's linear map.

package drc_pkg;
  // ****************************************************************
  // Memory map
  // ****************************************************************
  localparam logic [12:0] DRC_A_TEMP_HI = 13'h000B;
  localparam logic [12:0] DRC_A_TEMP_LO = 13'h000C;
  localparam logic [12:0] DRC_A_RATE = 13'h000D;
  localparam logic [12:0] DRC_A_CTL1 = 13'h000E;
  localparam logic [12:0] DRC_A_DLY_L = 13'h0012;
  localparam logic [12:0] DRC_A_DLY_H = 13'h0013;
  localparam logic [12:0] DRC_A_STAT = 13'h0014;
  localparam logic [12:0] DRC_A_SMP_L = 13'h001A;
  localparam logic [12:0] DRC_A_SMP_H = 13'h001B;
  localparam logic [12:0] DRC_A_CRC_L = 13'h0020;
  localparam logic [12:0] DRC_A_CRC_H = 13'h0021;
  localparam logic [12:0] DRC_A_CMD = 13'h0022;
  localparam logic [12:0] DRC_A_CHEN = 13'h0023;
  localparam logic [12:0] DRC_A_ADC_HI = 13'h0024;
  localparam logic [12:0] DRC_A_ADC_LO = 13'h0025;
  localparam logic [12:0] DRC_A_USER = 13'h0040;
  localparam logic [12:0] DRC_A_WR_END = 13'h0060;
  localparam logic [12:0] DRC_A_ALARM = 13'h0220;
  localparam logic [12:0] DRC_A_ALARM_END = 13'h0280;
  localparam logic [12:0] DRC_A_HIST = 13'h0800;
  localparam logic [12:0] DRC_A_HIST_END = 13'h0900;
  localparam logic [12:0] DRC_A_LOG = 13'h1000;
  localparam logic [12:0] DRC_A_LOG_END = 13'h1800;
  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int DRC_B_SE = 4;
  localparam int DRC_B_TLIE = 2;
  localparam int DRC_B_THIE = 1;
  localparam int DRC_B_AIE = 0;
  localparam int DRC_B_MIP = 5;
  localparam int DRC_B_CMD_START = 0;
  localparam int DRC_B_CMD_STOP = 1;
  localparam logic [7:0] DRC_CTL1_MASK = 8'h17;
  localparam logic [7:0] DRC_RST_RATE = 8'h01;
  localparam logic [3:0] DRC_RST_CHEN = 4'h1;
  localparam logic [15:0] DRC_CRC_POLY = 16'hA001;
  localparam logic [5:0] DRC_TBIN_MAX = 6'h3E;
  localparam logic [4:0] DRC_ALARM_WORDS = 5'h18;
  localparam logic [3:0] DRC_ALARM_PER_CH = 4'hC;
  localparam logic [7:0] DRC_DUR_MAX = 8'hFF;
  // ****************************************************************
  // Timing, in hertz, milliseconds, seconds and time base ticks
  // ****************************************************************
  localparam int DRC_TB_HZ = 32768;
  localparam int DRC_BTN_MS = 500;
  localparam int DRC_MIN_S = 60;
  localparam logic [14:0] DRC_BTN_TICKS = 15'((DRC_TB_HZ * DRC_BTN_MS) / 1000);
  localparam int DRC_MIN_TICKS = DRC_TB_HZ * DRC_MIN_S;

  typedef enum logic [5:0] {
    DRC_IDLE = 6'h01,
    DRC_CLR = 6'h02,
    DRC_DELAY = 6'h04,
    DRC_RUN = 6'h08,
    DRC_LOG = 6'h10,
    DRC_HIST = 6'h20
  } drc_state_t;
endpackage

// Three-flop chain and a level flop; a change counts once the last two agree
module drc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lv;
  } drc_sync_t;
  drc_sync_t q, d;

  always_comb
  begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (q.s2[i] == q.s3[i])
      begin
        d.lv[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign level = q.lv;
endmodule // drc_sync

// File: drc_core.sv
// Purpose: Mission control, memory map and host access of the data recorder.
// Assumes: Converter data on chan_data is stable while a sample is taken.
// Notes: Serial framing sits outside; host accesses arrive over Wishbone.
//
// Function
// - Link select high: only 3-wire link serves
// - Link select low: asynchronous pins serve host
// - Interrupt low while enabled flag set
// - Button start needs half second low
// - Button while logging reports data status
// - Sample every 1 to 255 minutes
// - One channel owns all 2048 slots
// - Two channels get 1024 slots each
// - Three or four channels: 512, grouped by four
// - Three channels: disabled slot written zero
// - Each sample adds one to bin
// - Temperature: 63 bins of 2 degrees
// - First analogue channel: 64 bins, top steps
// - Out of limits drives interrupt or status
// - Excursions stored with start and duration
// - Start by button or host command
// - Linear map of 32-byte pages
// - Host writes only control and user pages
// - Async mode: CRC-16 over read data

module drc_core #(
  parameter int MIN_TICKS = drc_pkg::DRC_MIN_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_type_select,
  input wire logic link_enable,
  input wire logic tb_32k,
  input wire logic start_button_n,
  input wire logic [31:0] chan_data,
  output logic tx_out,
  output logic tx_oe,
  output logic int_n_out,
  output logic int_n_oe,
  output logic within_limits_out_n,
  output logic within_limits_oe,
  output logic beyond_limits_out_n,
  output logic beyond_limits_oe
);
  typedef struct packed {
    drc_pkg::drc_state_t st;
    logic ack;
    logic [7:0] rdat;
    logic [7:0] ctl1;
    logic [7:0] t_hi;
    logic [7:0] t_lo;
    logic [7:0] a_hi;
    logic [7:0] a_lo;
    logic [7:0] rate;
    logic [15:0] delay;
    logic [3:0] chen;
    logic [2:0] flg;
    logic ever_out;
    logic [15:0] crc;
    logic [14:0] btn_cnt;
    logic tb_prev;
    logic [31:0] tb_cnt;
    logic [15:0] min_cnt;
    logic [23:0] stamp;
    logic [10:0] smp;
    logic [1:0] ch;
    logic rank;
    logic [6:0] clr;
    logic [1:0] exc;
    logic [15:0] dur;
    logic [7:0] aptr;
    logic int_oe;
    logic win_oe;
    logic bey_oe;
    logic tx_oe;
  } drc_core_t;

  drc_core_t q, d;
  logic [3:0] pins;
  logic lsel, lenable, tb, btn_n;
  logic [7:0] uram [32];
  logic [7:0] dlog [2048];
  logic [15:0] hist [128];
  logic [31:0] alarm [24];
  logic uwe, lwe, clr_we;
  logic [10:0] laddr;
  logic [7:0] ldat;
  logic [1:0] hwe, aw_full, aw_dur;
  logic [6:0] haddr [2];
  logic [4:0] awa [2];
  logic [7:0] durb [2];

  drc_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin({link_type_select, link_enable, tb_32k, start_button_n}),
    .level(pins)
  );
  assign {lsel, lenable, tb, btn_n} = pins;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ drc_pkg::DRC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic acc, permit, wr, tb_rise, min_tick, start, logging, held;
    logic [12:0] a, off;
    logic [7:0] rb, val;
    logic [2:0] n_en;
    logic [5:0] tbin;
    logic [1:0] outl;
    d = q;
    acc = 1'b0;
    permit = 1'b0;
    wr = 1'b0;
    tb_rise = 1'b0;
    min_tick = 1'b0;
    start = 1'b0;
    logging = 1'b0;
    held = 1'b0;
    a = wb_adr_i[14:2];
    off = 13'h0000;
    rb = 8'h00;
    val = 8'h00;
    n_en = 3'(q.chen[0]) + 3'(q.chen[1]) + 3'(q.chen[2]) + 3'(q.chen[3]);
    tbin = 6'h00;
    outl = 2'b00;
    uwe = 1'b0;
    lwe = 1'b0;
    clr_we = 1'b0;
    laddr = q.smp;
    ldat = 8'h00;
    hwe = 2'b00;
    aw_full = 2'b00;
    aw_dur = 2'b00;
    haddr[0] = 7'h00;
    haddr[1] = 7'h00;
    awa[0] = 5'h00;
    awa[1] = 5'h00;
    durb[0] = q.dur[7:0];
    durb[1] = q.dur[15:8];

    // 3-wire mode serves only while its enable pin is high
    // asynchronous pins active when select is low
    permit = ~lsel | lenable;
    d.tx_oe = ~lsel;
    acc = wb_cyc_i & wb_stb_i & ~q.ack;
    d.ack = acc;
    // writes below the end of the user page only
    wr = acc & wb_we_i & wb_sel_i[0] & permit & ~wb_adr_i[15] & (a < drc_pkg::DRC_A_WR_END);

    if (wb_adr_i[15] || a >= drc_pkg::DRC_A_LOG_END)
    begin
      rb = 8'h00;
    end
    else if (a >= drc_pkg::DRC_A_LOG)
    begin
      off = a - drc_pkg::DRC_A_LOG;
      rb = dlog[off[10:0]];
    end
    else if (a >= drc_pkg::DRC_A_HIST && a < drc_pkg::DRC_A_HIST_END)
    begin
      off = a - drc_pkg::DRC_A_HIST;
      rb = off[0] ? hist[off[7:1]][15:8] : hist[off[7:1]][7:0];
    end
    else if (a >= drc_pkg::DRC_A_ALARM && a < drc_pkg::DRC_A_ALARM_END)
    begin
      off = a - drc_pkg::DRC_A_ALARM;
      rb = alarm[off[6:2]][{off[1:0], 3'b000} +: 8];
    end
    else if (a >= drc_pkg::DRC_A_USER && a < drc_pkg::DRC_A_WR_END)
    begin
      rb = uram[a[4:0]];
    end
    else
    begin
      case (a)
        drc_pkg::DRC_A_TEMP_HI: rb = q.t_hi;
        drc_pkg::DRC_A_TEMP_LO: rb = q.t_lo;
        drc_pkg::DRC_A_RATE: rb = q.rate;
        drc_pkg::DRC_A_CTL1: rb = q.ctl1;
        drc_pkg::DRC_A_DLY_L: rb = q.delay[7:0];
        drc_pkg::DRC_A_DLY_H: rb = q.delay[15:8];
        drc_pkg::DRC_A_STAT: rb = {2'b00, q.st != drc_pkg::DRC_IDLE, 2'b00, q.flg};
        drc_pkg::DRC_A_SMP_L: rb = q.smp[7:0];
        drc_pkg::DRC_A_SMP_H: rb = {5'h00, q.smp[10:8]};
        drc_pkg::DRC_A_CRC_L: rb = q.crc[7:0];
        drc_pkg::DRC_A_CRC_H: rb = q.crc[15:8];
        drc_pkg::DRC_A_CHEN: rb = {4'h0, q.chen};
        drc_pkg::DRC_A_ADC_HI: rb = q.a_hi;
        drc_pkg::DRC_A_ADC_LO: rb = q.a_lo;
        default: rb = 8'h00;
      endcase
    end
    d.rdat = (acc & ~wb_we_i & permit) ? rb : 8'h00;
    // read data folded into the CRC in async mode
    if (acc && !wb_we_i && !lsel)
    begin
      d.crc = crc_step(q.crc, rb);
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    if (wr)
    begin
      val = wb_dat_i[7:0];
      uwe = a >= drc_pkg::DRC_A_USER;
      case (a)
        drc_pkg::DRC_A_TEMP_HI: d.t_hi = val;
        drc_pkg::DRC_A_TEMP_LO: d.t_lo = val;
        drc_pkg::DRC_A_RATE: d.rate = val;
        drc_pkg::DRC_A_CTL1: d.ctl1 = val & drc_pkg::DRC_CTL1_MASK;
        drc_pkg::DRC_A_DLY_L: d.delay[7:0] = val;
        drc_pkg::DRC_A_DLY_H: d.delay[15:8] = val;
        drc_pkg::DRC_A_STAT: d.flg = q.flg & val[2:0];
        drc_pkg::DRC_A_CRC_L: d.crc = 16'h0000;
        drc_pkg::DRC_A_CRC_H: d.crc = 16'h0000;
        // host command starts or stops a mission
        drc_pkg::DRC_A_CMD: start = val[drc_pkg::DRC_B_CMD_START];
        drc_pkg::DRC_A_CHEN: d.chen = val[3:0];
        drc_pkg::DRC_A_ADC_HI: d.a_hi = val;
        drc_pkg::DRC_A_ADC_LO: d.a_lo = val;
        default: d.ctl1 = q.ctl1;
      endcase
      if (a == drc_pkg::DRC_A_CMD && val[drc_pkg::DRC_B_CMD_STOP])
      begin
        d.st = drc_pkg::DRC_IDLE;
      end
    end

    // ****************************************************************
    // Time base and button
    // ****************************************************************
    d.tb_prev = tb;
    tb_rise = tb & ~q.tb_prev;
    if (tb_rise)
    begin
      min_tick = q.tb_cnt == 32'(MIN_TICKS - 1);
      d.tb_cnt = min_tick ? 32'h00000000 : q.tb_cnt + 32'h00000001;
    end
    // low time counted in time base ticks, restart on high
    if (btn_n)
    begin
      d.btn_cnt = 15'h0000;
    end
    else if (tb_rise && q.btn_cnt != drc_pkg::DRC_BTN_TICKS)
    begin
      d.btn_cnt = q.btn_cnt + 15'h0001;
    end
    held = (q.btn_cnt != drc_pkg::DRC_BTN_TICKS) && (d.btn_cnt == drc_pkg::DRC_BTN_TICKS);
    // button start after half a second low
    if (q.ctl1[drc_pkg::DRC_B_SE] && held)
    begin
      start = 1'b1;
    end

    logging = q.st != drc_pkg::DRC_IDLE && q.st != drc_pkg::DRC_DELAY && q.st != drc_pkg::DRC_CLR;
    // button press while logging shows data status
    d.win_oe = logging & ~btn_n & ~q.ever_out;
    d.bey_oe = logging & ~btn_n & q.ever_out;
    // interrupt while an enabled flag stands
    // limit flags reach the interrupt pin
    d.int_oe = |(q.flg & {q.ctl1[drc_pkg::DRC_B_TLIE], q.ctl1[drc_pkg::DRC_B_THIE],
                          q.ctl1[drc_pkg::DRC_B_AIE]});
    if (q.st != drc_pkg::DRC_IDLE && min_tick)
    begin
      d.stamp = q.stamp + 24'h000001;
    end

    // ****************************************************************
    // Mission sequence
    // ****************************************************************
    case (q.st)
      drc_pkg::DRC_IDLE:
      begin
        if (start)
        begin
          d.st = drc_pkg::DRC_CLR;
          d.clr = 7'h00;
          d.smp = 11'h000;
          d.stamp = 24'h000000;
          d.ever_out = 1'b0;
          d.exc = 2'b00;
          d.aptr = 8'h00;
        end
      end
      drc_pkg::DRC_CLR:
      begin
        clr_we = 1'b1;
        d.clr = q.clr + 7'h01;
        if (q.clr == 7'h7F)
        begin
          d.st = drc_pkg::DRC_DELAY;
          d.min_cnt = q.delay;
        end
      end
      drc_pkg::DRC_DELAY:
      begin
        if (q.min_cnt == 16'h0000)
        begin
          d.st = drc_pkg::DRC_LOG;
          d.ch = 2'b00;
          d.rank = 1'b0;
          d.min_cnt = {8'h00, q.rate};
        end
        else if (min_tick)
        begin
          d.min_cnt = q.min_cnt - 16'h0001;
        end
      end
      drc_pkg::DRC_RUN:
      begin
        // wake once per programmed number of minutes
        if (min_tick)
        begin
          if (q.min_cnt <= 16'h0001)
          begin
            d.st = drc_pkg::DRC_LOG;
            d.ch = 2'b00;
            d.rank = 1'b0;
            d.min_cnt = {8'h00, q.rate};
          end
          else
          begin
            d.min_cnt = q.min_cnt - 16'h0001;
          end
        end
      end
      drc_pkg::DRC_LOG:
      begin
        if (n_en >= 3'd3)
        begin
          lwe = 1'b1;
          laddr = {q.smp[8:0], q.ch};
          ldat = q.chen[q.ch] ? chan_data[{q.ch, 3'b000} +: 8] : 8'h00;
        end
        else if (q.chen[q.ch])
        begin
          lwe = 1'b1;
          laddr = (n_en == 3'd1) ? q.smp : {q.smp[9:0], q.rank};
          ldat = chan_data[{q.ch, 3'b000} +: 8];
          d.rank = ~q.rank;
        end
        d.ch = q.ch + 2'b01;
        if (q.ch == 2'b11)
        begin
          d.st = drc_pkg::DRC_HIST;
        end
      end
      drc_pkg::DRC_HIST:
      begin
        // 2 degree bins, top bin clamped at 63rd
        tbin = (chan_data[7:2] > drc_pkg::DRC_TBIN_MAX) ? drc_pkg::DRC_TBIN_MAX : chan_data[7:2];
        hwe = 2'b11;
        haddr[0] = {1'b0, tbin};
        haddr[1] = {1'b1, chan_data[15:10]};
        // compare against high and low trip points
        if (chan_data[7:0] > q.t_hi)
        begin
          d.flg[drc_pkg::DRC_B_THIE] = 1'b1;
        end
        if (chan_data[7:0] < q.t_lo)
        begin
          d.flg[drc_pkg::DRC_B_TLIE] = 1'b1;
        end
        outl[0] = chan_data[7:0] > q.t_hi || chan_data[7:0] < q.t_lo;
        outl[1] = chan_data[15:8] > q.a_hi || chan_data[15:8] < q.a_lo;
        if (outl[1])
        begin
          d.flg[drc_pkg::DRC_B_AIE] = 1'b1;
        end
        if (|outl)
        begin
          d.ever_out = 1'b1;
        end
        // open entry on entry, write duration on exit
        for (int i = 0; i < 2; i++)
        begin
          awa[i] = 5'(q.aptr[i*4 +: 4]) + (i == 1 ? 5'(drc_pkg::DRC_ALARM_PER_CH) : 5'h00);
          if (outl[i] && !q.exc[i])
          begin
            aw_full[i] = 1'b1;
            d.dur[i*8 +: 8] = 8'h01;
            d.exc[i] = 1'b1;
          end
          else if (outl[i] && q.dur[i*8 +: 8] != drc_pkg::DRC_DUR_MAX)
          begin
            d.dur[i*8 +: 8] = q.dur[i*8 +: 8] + 8'h01;
          end
          else if (!outl[i] && q.exc[i])
          begin
            aw_dur[i] = 1'b1;
            d.exc[i] = 1'b0;
            d.aptr[i*4 +: 4] = (q.aptr[i*4 +: 4] == drc_pkg::DRC_ALARM_PER_CH - 4'h1) ? 4'h0
                               : q.aptr[i*4 +: 4] + 4'h1;
          end
        end
        d.smp = q.smp + 11'h001;
        d.st = drc_pkg::DRC_RUN;
      end
      default: d.st = drc_pkg::DRC_IDLE;
    endcase
  end

  // ****************************************************************
  // State and memories
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.st <= drc_pkg::DRC_IDLE;
      q.rate <= drc_pkg::DRC_RST_RATE;
      q.chen <= drc_pkg::DRC_RST_CHEN;
    end
    else
    begin
      q <= d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (uwe)
    begin
      uram[wb_adr_i[6:2]] <= wb_dat_i[7:0];
    end
    if (lwe)
    begin
      dlog[laddr] <= ldat;
    end
    if (clr_we)
    begin
      hist[q.clr] <= 16'h0000;
      if (q.clr[4:0] < drc_pkg::DRC_ALARM_WORDS && !q.clr[6] && !q.clr[5])
      begin
        alarm[q.clr[4:0]] <= 32'h00000000;
      end
    end
    for (int i = 0; i < 2; i++)
    begin
      if (hwe[i])
      begin
        hist[haddr[i]] <= hist[haddr[i]] + 16'h0001;
      end
      if (aw_full[i])
      begin
        alarm[awa[i]] <= {8'h00, q.stamp};
      end
      else if (aw_dur[i])
      begin
        alarm[awa[i]][31:24] <= durb[i];
      end
    end
  end

  assign wb_dat_o = {24'h000000, q.rdat};
  assign wb_ack_o = q.ack;
  assign tx_out = 1'b1;
  assign tx_oe = q.tx_oe;
  assign int_n_out = 1'b0;
  assign int_n_oe = q.int_oe;
  assign within_limits_out_n = 1'b0;
  assign within_limits_oe = q.win_oe;
  assign beyond_limits_out_n = 1'b0;
  assign beyond_limits_oe = q.bey_oe;
endmodule // drc_core

// File: drc_core_checker.sv
// Purpose: Bus and pin checks on the data recorder core.
// Assumes: Sees only the core's ports.
// Notes: Pin paths get six edges to pass the synchroniser.
module drc_core_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic link_type_select,
  input wire logic start_button_n,
  input wire logic tx_oe,
  input wire logic within_limits_oe,
  input wire logic beyond_limits_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bytes not zero");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[15] |-> !(|wb_dat_o))
    else $error("unmapped read not zero");
  a_async_drive: assert property (!link_type_select [*6] |-> tx_oe)
    else $error("transmit pin idle in async mode");
  a_sync_quiet: assert property (link_type_select [*6] |-> !tx_oe)
    else $error("transmit pin driven in 3-wire mode");
  a_status_idle: assert property (start_button_n [*6] |-> !(within_limits_oe || beyond_limits_oe))
    else $error("status pins driven without button");
  a_status_one: assert property (!(within_limits_oe && beyond_limits_oe))
    else $error("both status pins driven");

  c_within: cover property (within_limits_oe);
  c_beyond: cover property (beyond_limits_oe);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule // drc_core_checker

bind drc_core drc_core_checker i_drc_core_checker (
  .clk(clk),
  .rst(rst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .link_type_select(link_type_select),
  .start_button_n(start_button_n),
  .tx_oe(tx_oe),
  .within_limits_oe(within_limits_oe),
  .beyond_limits_oe(beyond_limits_oe)
);

// File: drc_time_model.sv
// Purpose: Crystal time base seen by the recorder.
// Assumes: Runs free, unrelated in phase to the system clock.
// Notes: 400 ns period stands in for the slow crystal.
module drc_time_model (
  output logic tb_32k
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    tb_32k = 1'b0;
    #13;
    forever #200 tb_32k = ~tb_32k;
  end
endmodule // drc_time_model

// File: drc_core_test.sv
// Purpose: Self-checking bench of the recorder core.
// Assumes: A minute is shortened to 4 time base ticks.
// Notes: Host side is a Wishbone master made of tasks.
module drc_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cyc, stb, we, ack, lts, len, btn_n, tb_32k;
  logic tx_oe, int_oe, wl_oe, bl_oe;
  logic [15:0] adr;
  logic [31:0] wdat, rdat, chan;
  logic [3:0] sel;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  drc_core #(.MIN_TICKS(4)) i_drc_core (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link_type_select(lts), .link_enable(len), .tb_32k(tb_32k), .start_button_n(btn_n),
    .chan_data(chan), .tx_out(), .tx_oe(tx_oe), .int_n_out(), .int_n_oe(int_oe),
    .within_limits_out_n(), .within_limits_oe(wl_oe),
    .beyond_limits_out_n(), .beyond_limits_oe(bl_oe)
  );
  drc_time_model i_drc_time_model (.tb_32k(tb_32k));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****
  // Bus and compare tasks
  // ****
  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
      n_mismatch++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, {1'b0, a, 2'b00}, d, q);
  endtask
  task automatic chk(input string what, input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, {1'b0, a, 2'b00}, 8'h00, q);
    cmp(what, {8'h00, e}, {8'h00, q});
  endtask
  function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ drc_pkg::DRC_CRC_POLY : c >> 1;
    return c;
  endfunction
  task automatic run_mission(input logic [3:0] ch, input logic out, output logic [7:0] n);
    logic [7:0] q;
    wr(13'h023, {4'h0, ch});
    wr(13'h022, 8'h01);
    repeat (400) @(posedge clk);
    btn_n <= 1'b0;
    repeat (8) @(posedge clk);
    cmp("beyond pin", {15'h0000, out}, {15'h0000, bl_oe});
    cmp("within pin", {15'h0000, !out}, {15'h0000, wl_oe});
    btn_n <= 1'b1;
    repeat (8) @(posedge clk);
    cmp("pins idle", 16'h0000, {14'h0000, bl_oe, wl_oe});
    wr(13'h022, 8'h02);
    wb(1'b0, 16'h0068, 8'h00, n);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    logic [7:0] q;
    chk("rate", 13'h00D, 8'h01);
    chk("chan enable", 13'h023, 8'h01);
    wr(13'h040, 8'hA5);
    wr(13'h041, 8'h5A);
    wr(13'h060, 8'h33);
    wr(13'h00E, 8'hFF);
    chk("user ram", 13'h040, 8'hA5);
    chk("user ram hi", 13'h041, 8'h5A);
    chk("reserved", 13'h060, 8'h00);
    chk("control", 13'h00E, 8'h17);
    wb(1'b0, 16'h8004, 8'h00, q);
    cmp("unmapped", 16'h0000, {8'h00, q});
    wr(13'h00E, 8'h00);
    wr(13'h00B, 8'hFF);
    wr(13'h024, 8'hFF);
  endtask
  task automatic t_crc();
    logic [15:0] c;
    wr(13'h020, 8'h00);
    chk("ram a", 13'h040, 8'hA5);
    chk("ram b", 13'h041, 8'h5A);
    c = crc_upd(crc_upd(16'h0000, 8'hA5), 8'h5A);
    chk("crc low", 13'h020, c[7:0]);
    c = crc_upd(c, c[7:0]);
    chk("crc high", 13'h021, c[15:8]);
  endtask
  task automatic t_link();
    lts <= 1'b1;
    repeat (8) @(posedge clk);
    wr(13'h041, 8'h77);
    chk("closed link", 13'h041, 8'h00);
    len <= 1'b1;
    repeat (8) @(posedge clk);
    chk("open link", 13'h041, 8'h5A);
    lts <= 1'b0;
    len <= 1'b0;
    repeat (8) @(posedge clk);
    chk("async link", 13'h040, 8'hA5);
  endtask
  task automatic t_one();
    logic [7:0] n;
    run_mission(4'h1, 1'b0, n);
    cmp("sample count", 16'h0001, {15'h0000, n >= 8'h07 && n <= 8'h0A});
    chk("log first", 13'h1000, 8'h14);
    chk("log last", 13'h1000 + {5'h00, n} - 13'h0001, 8'h14);
    wr(13'h080A, 8'hFF);
    chk("temp bin", 13'h080A, n);
    chk("next bin", 13'h080C, 8'h00);
    chk("stopped", 13'h014, 8'h00);
  endtask
  task automatic t_two();
    logic [7:0] n;
    run_mission(4'h3, 1'b0, n);
    chk("two ch0", 13'h1000, 8'h14);
    chk("two ch1", 13'h1001, 8'h22);
    chk("two ch0 next", 13'h1002, 8'h14);
    chk("adc bin", 13'h0890, n);
  endtask
  task automatic t_three();
    logic [7:0] n;
    logic [7:0] e [5] = '{8'h14, 8'h22, 8'h33, 8'h00, 8'h14};
    run_mission(4'h7, 1'b0, n);
    for (int i = 0; i < 5; i++)
      chk("three ch slot", 13'h1000 + 13'(i), e[i]);
  endtask
  task automatic t_alarm();
    logic [7:0] n;
    wr(13'h00B, 8'h10);
    wr(13'h00E, 8'h02);
    // Temperature back in limits mid-mission closes the excursion
    fork
      run_mission(4'h1, 1'b1, n);
      begin
        repeat (300) @(posedge clk);
        chan <= 32'h44332208;
      end
    join
    chk("high flag", 13'h014, 8'h02);
    cmp("irq on", 16'h0001, {15'h0000, int_oe});
    wb(1'b0, 16'h088C, 8'h00, n);
    cmp("alarm span", 16'h0001, {15'h0000, n >= 8'h05 && n <= 8'h08});
    chan <= 32'h44332214;
    wr(13'h014, 8'h00);
    repeat (2) @(posedge clk);
    cmp("irq off", 16'h0000, {15'h0000, int_oe});
    wr(13'h00B, 8'hFF);
  endtask
  task automatic t_button();
    wr(13'h00E, 8'h10);
    btn_n <= 1'b0;
    repeat (200) @(posedge clk);
    btn_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("short press", 13'h014, 8'h00);
    wr(13'h00E, 8'h00);
  endtask

  initial
  begin
    rst = 1'b1;
    {cyc, stb, we, lts, len} = 5'h00;
    btn_n = 1'b1;
    adr = 16'h0000;
    wdat = 32'h00000000;
    sel = 4'hF;
    chan = 32'h44332214;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_regs();
    t_crc();
    t_link();
    t_one();
    t_two();
    t_three();
    t_alarm();
    t_button();
    end_sim();
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
endmodule // drc_core_test
